// File: hw/dmace_pkg.sv
// Purpose: shared types and constants for the two-channel transfer engine
// Assumes: one 10 MHz clock, synchronous active-low reset
// Notes: channel parameter sets travel as packed structs
package dmace_pkg;
   localparam int DMACE_AW = 26;
   localparam int DMACE_CW = 24;
   localparam logic [DMACE_CW-1:0] DMACE_COUNT_RESET = 24'h000000;
   localparam logic [DMACE_AW-1:0] DMACE_ADDR_RESET = 26'h0000000;
   localparam logic [2:0] DMACE_STAGE_BYTES = 3'h4;
   localparam logic [1:0] DMACE_RANK_RESET0 = 2'h0;
   localparam logic [1:0] DMACE_RANK_RESET1 = 2'h1;
   localparam logic [1:0] DMACE_RANK_RESET2 = 2'h2;
   localparam logic [1:0] DMACE_OWN_NONE = 2'h3;

   typedef enum logic [1:0] {DMACE_ADDR_INC, DMACE_ADDR_DEC, DMACE_ADDR_HOLD} dmace_step_type;
   typedef enum logic [1:0] {DMACE_BUF_SINGLE, DMACE_BUF_AUTO, DMACE_BUF_CHAIN} dmace_bufmode_type;

   typedef struct packed {
      logic [DMACE_AW-1:0] req_addr;
      logic [DMACE_AW-1:0] tgt_addr;
      logic [DMACE_CW-1:0] count;
   } dmace_xfer_type;

   typedef struct packed {
      logic fly_by;
      logic req_is_src;
      logic req_is_mem;
      logic req_ext_io;
      logic tgt_is_mem;
      logic req_word;
      logic tgt_word;
      logic eop_sync;
      dmace_step_type req_step;
      dmace_step_type tgt_step;
      dmace_bufmode_type bufmode;
      logic [2:0] hw_src_sel;
   } dmace_cfg_type;

   typedef struct packed {
      logic [DMACE_AW-1:0] addr;
      logic mem;
      logic write;
      logic word;
      logic [15:0] wdata;
   } dmace_cycle_type;
endpackage

// File: hw/dmace_channel.sv
// Purpose: one transfer channel with staging buffer and buffer modes
// Assumes: bus grant and cycle completion from the engine top
// Notes: count going below zero (top bit set after the decrement) is expiry
`timescale 1ns/1ns
module dmace_channel (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire dmace_pkg::dmace_cfg_type cfg,
   input wire dmace_pkg::dmace_xfer_type prog,
   input wire logic prog_we,
   input wire logic request,
   input wire logic granted,
   input wire logic cycle_done,
   input wire logic [15:0] rdata,
   input wire logic eop_in,
   output logic want_bus,
   output logic active,
   output logic ack,
   output logic done_pulse,
   output dmace_pkg::dmace_cycle_type cyc
);
   import dmace_pkg::*;
   typedef enum logic [1:0] {CH_IDLE, CH_READ, CH_WRITE, CH_FLY} ch_state_type;
   ch_state_type st_reg, st_next;
   dmace_xfer_type cur_reg, base_reg, chain_reg;
   logic armed_reg, chain_valid_reg, pend_reg, ending_reg;
   logic [7:0] stage_reg [0:3];
   logic [2:0] fill_reg, drain_reg;

   function automatic logic [DMACE_AW-1:0] step_addr(input logic [DMACE_AW-1:0] a,
      input dmace_step_type s, input logic w);
      logic [DMACE_AW-1:0] d;
      d = w ? 26'h0000002 : 26'h0000001;
      case (s)
         DMACE_ADDR_INC: step_addr = a + d;
         DMACE_ADDR_DEC: step_addr = a - d;
         default: step_addr = a;
      endcase
   endfunction

   wire fly_ok = cfg.fly_by && cfg.req_ext_io && cfg.tgt_is_mem;
   wire src_word = cfg.req_is_src ? cfg.req_word : cfg.tgt_word;
   wire dst_word = cfg.req_is_src ? cfg.tgt_word : cfg.req_word;
   wire unit_word = fly_ok ? cfg.tgt_word : src_word;
   wire [DMACE_CW-1:0] dec = unit_word ? 24'h000002 : 24'h000001;
   wire [DMACE_CW-1:0] cnt_after = cur_reg.count - dec;
   wire expire = cnt_after[DMACE_CW-1];
   wire src_done = cycle_done && (st_reg == CH_READ || st_reg == CH_FLY);
   wire term = src_done && (expire || eop_in);
   wire [2:0] fill_after = fill_reg + (src_word ? 3'h2 : 3'h1);
   wire [2:0] drain_after = drain_reg + (dst_word ? 3'h2 : 3'h1);
   wire start = armed_reg && request && granted;
   wire src_req = cfg.req_is_src;

   always_comb begin
      st_next = st_reg;
      case (st_reg)
         CH_IDLE: if (start) st_next = fly_ok ? CH_FLY : CH_READ;
         CH_FLY: if (term || (cycle_done && !request)) st_next = CH_IDLE;
         CH_READ: begin
            if (term || (src_done && fill_after >= DMACE_STAGE_BYTES)) begin
               st_next = CH_WRITE;
            end else if (src_done && !request) begin
               st_next = CH_IDLE;
            end
         end
         CH_WRITE: if (cycle_done && drain_after >= fill_reg) st_next = ending_reg ? CH_IDLE : CH_READ;
         default: st_next = CH_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_reg <= CH_IDLE;
         cur_reg <= '0;
         base_reg <= '0;
         chain_reg <= '0;
         armed_reg <= 1'b0;
         chain_valid_reg <= 1'b0;
         pend_reg <= 1'b0;
         ending_reg <= 1'b0;
         fill_reg <= 3'h0;
         drain_reg <= 3'h0;
         done_pulse <= 1'b0;
         for (int i = 0; i < 4; i++) stage_reg[i] <= 8'h00;
      end else if (ce) begin
         st_reg <= st_next;
         done_pulse <= 1'b0;
         if (prog_we && st_reg != CH_IDLE && cfg.bufmode == DMACE_BUF_CHAIN) begin
            chain_reg <= prog;
            chain_valid_reg <= 1'b1;
         end else if (prog_we) begin
            cur_reg <= prog;
            base_reg <= prog;
            armed_reg <= 1'b1;
         end
         if (src_done) begin
            cur_reg.count <= cnt_after;
            cur_reg.req_addr <= step_addr(cur_reg.req_addr, cfg.req_step, cfg.req_word);
            cur_reg.tgt_addr <= step_addr(cur_reg.tgt_addr, cfg.tgt_step, cfg.tgt_word);
            if (st_reg == CH_READ) begin
               stage_reg[fill_reg[1:0]] <= rdata[7:0];
               if (src_word) stage_reg[fill_reg[1:0] + 2'h1] <= rdata[15:8];
               fill_reg <= fill_after;
            end
         end
         if (term) ending_reg <= 1'b1;
         if (cycle_done && st_reg == CH_WRITE) begin
            drain_reg <= drain_after;
            if (drain_after >= fill_reg) begin
               fill_reg <= 3'h0;
               drain_reg <= 3'h0;
            end
         end
         if ((st_reg == CH_FLY && term) || (st_reg == CH_WRITE && st_next != CH_WRITE && ending_reg)) begin
            done_pulse <= 1'b1;
            ending_reg <= 1'b0;
            case (cfg.bufmode)
               DMACE_BUF_AUTO: cur_reg <= base_reg;
               DMACE_BUF_CHAIN: begin
                  if (chain_valid_reg) cur_reg <= chain_reg;
                  else if (prog_we) cur_reg <= prog;
                  armed_reg <= chain_valid_reg || prog_we;
                  chain_valid_reg <= chain_valid_reg && prog_we;
               end
               default: armed_reg <= 1'b0;
            endcase
         end
         pend_reg <= request && armed_reg;
      end
   end

   wire rd_phase = st_reg == CH_READ;
   wire at_req = st_reg == CH_FLY || (rd_phase == src_req);
   assign want_bus = armed_reg && (pend_reg || st_reg != CH_IDLE);
   assign active = st_reg != CH_IDLE;
   assign ack = (st_reg == CH_FLY) || (active && !cfg.req_is_mem && at_req && st_reg != CH_IDLE);
   always_comb begin
      cyc.addr = at_req && st_reg != CH_FLY ? cur_reg.req_addr : cur_reg.tgt_addr;
      cyc.mem = st_reg == CH_FLY ? 1'b1 : (at_req ? cfg.req_is_mem : cfg.tgt_is_mem);
      cyc.write = st_reg == CH_FLY ? src_req : st_reg == CH_WRITE;
      cyc.word = rd_phase ? src_word : dst_word;
      cyc.wdata = {stage_reg[drain_reg[1:0] + 2'h1], stage_reg[drain_reg[1:0]]};
   end
endmodule // dmace_channel

// File: hw/dmace_engine.sv
// Purpose: two-channel transfer engine with bus arbiter
// Assumes: pins pass two flip-flops; internal peripheral requests are same-clock
// Notes: all outputs registered
`timescale 1ns/1ns
module dmace_engine (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [1:0] channel_request,
   input wire logic [3:0] periph_req0,
   input wire logic [3:0] periph_req1,
   input wire logic [1:0] sw_request,
   input wire dmace_pkg::dmace_cfg_type cfg0,
   input wire dmace_pkg::dmace_cfg_type cfg1,
   input wire dmace_pkg::dmace_xfer_type prog,
   input wire logic [1:0] prog_we,
   input wire logic refresh_req,
   input wire logic hold_req,
   input wire logic rotate_en,
   input wire logic low_sel_we,
   input wire logic [1:0] low_sel,
   input wire logic cycle_done,
   input wire logic [15:0] rdata,
   input wire logic end_of_process_line_in,
   output logic end_of_process_line_out,
   output logic end_of_process_line_oe,
   output logic [1:0] channel_acknowledge_n,
   output logic refresh_grant,
   output logic hold_grant,
   output logic [1:0] channel_busy,
   output logic cycle_start,
   output dmace_pkg::dmace_cycle_type cycle
);
   import dmace_pkg::*;
   logic [1:0] drq_s1_reg, drq_s2_reg;
   logic eop_s1_reg, eop_s2_reg, eop_seen_reg;
   logic [1:0] rank_reg [0:2];
   logic [1:0] owner_reg;
   logic [1:0] want, act, ack, done;
   logic [1:0] req_all;
   logic [1:0] eop_ch;
   dmace_cycle_type cyc0, cyc1;

   function automatic logic hw_pick(input logic [2:0] sel, input logic pin, input logic [3:0] p);
      hw_pick = (sel == 3'h0) ? pin : p[sel[1:0] - 2'h1] & (sel <= 3'h4);
   endfunction

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         drq_s1_reg <= 2'h0;
         drq_s2_reg <= 2'h0;
         eop_s1_reg <= 1'b0;
         eop_s2_reg <= 1'b0;
      end else if (ce) begin
         drq_s1_reg <= channel_request;
         drq_s2_reg <= drq_s1_reg;
         // own completion pulse must not echo back as a terminate request
         eop_s1_reg <= ~end_of_process_line_in & ~end_of_process_line_oe;
         eop_s2_reg <= eop_s1_reg;
      end
   end

   assign req_all[0] = hw_pick(cfg0.hw_src_sel, drq_s2_reg[0], periph_req0) | sw_request[0];
   assign req_all[1] = hw_pick(cfg1.hw_src_sel, drq_s2_reg[1], periph_req1) | sw_request[1];
   // sync mode latches assertion seen during the transfer, async acts on the current sample
   assign eop_ch[0] = cfg0.eop_sync ? (eop_seen_reg | eop_s2_reg) : eop_s2_reg;
   assign eop_ch[1] = cfg1.eop_sync ? (eop_seen_reg | eop_s2_reg) : eop_s2_reg;

   dmace_channel u_ch0 (.clk(clk), .rst_n(rst_n), .ce(ce), .cfg(cfg0), .prog(prog),
      .prog_we(prog_we[0]), .request(req_all[0]), .granted(owner_reg == 2'h0),
      .cycle_done(cycle_done && owner_reg == 2'h0), .rdata(rdata), .eop_in(eop_ch[0]),
      .want_bus(want[0]), .active(act[0]), .ack(ack[0]), .done_pulse(done[0]), .cyc(cyc0));
   dmace_channel u_ch1 (.clk(clk), .rst_n(rst_n), .ce(ce), .cfg(cfg1), .prog(prog),
      .prog_we(prog_we[1]), .request(req_all[1]), .granted(owner_reg == 2'h1),
      .cycle_done(cycle_done && owner_reg == 2'h1), .rdata(rdata), .eop_in(eop_ch[1]),
      .want_bus(want[1]), .active(act[1]), .ack(ack[1]), .done_pulse(done[1]), .cyc(cyc1));

   wire [2:0] pend = {hold_req, want[1], want[0]};
   wire hit0 = pend[rank_reg[0]];
   wire hit1 = pend[rank_reg[1]];
   wire hit2 = pend[rank_reg[2]];
   wire [1:0] winner = hit0 ? rank_reg[0] : hit1 ? rank_reg[1] : hit2 ? rank_reg[2] : DMACE_OWN_NONE;
   wire owner_free = owner_reg == DMACE_OWN_NONE;
   wire owner_rel = !owner_free && !pend[owner_reg];
   wire take = owner_free && !refresh_req && winner != DMACE_OWN_NONE;

   function automatic logic [1:0] after_low(input logic [1:0] low, input int k);
      logic [2:0] s;
      s = {1'b0, low} + 3'(k) + 3'h1;
      after_low = (s >= 3'h3) ? 2'(s - 3'h3) : s[1:0];
   endfunction

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rank_reg[0] <= DMACE_RANK_RESET0;
         rank_reg[1] <= DMACE_RANK_RESET1;
         rank_reg[2] <= DMACE_RANK_RESET2;
         owner_reg <= DMACE_OWN_NONE;
         refresh_grant <= 1'b0;
         hold_grant <= 1'b0;
      end else if (ce) begin
         refresh_grant <= owner_free && refresh_req;
         if (owner_rel) begin
            owner_reg <= DMACE_OWN_NONE;
         end else if (take) begin
            owner_reg <= winner;
            if (rotate_en) begin
               for (int k = 0; k < 3; k++) rank_reg[k] <= after_low(winner, k);
            end
         end
         if (low_sel_we && low_sel != DMACE_OWN_NONE) begin
            for (int k = 0; k < 3; k++) rank_reg[k] <= after_low(low_sel, k);
         end
         hold_grant <= (owner_reg == 2'h2) && hold_req;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         eop_seen_reg <= 1'b0;
         end_of_process_line_out <= 1'b0;
         end_of_process_line_oe <= 1'b0;
         channel_acknowledge_n <= 2'h3;
         channel_busy <= 2'h0;
         cycle_start <= 1'b0;
         cycle <= '0;
      end else if (ce) begin
         eop_seen_reg <= (act != 2'h0) && (eop_seen_reg || eop_s2_reg) && !cycle_done;
         end_of_process_line_out <= 1'b0;
         end_of_process_line_oe <= done != 2'h0;
         channel_acknowledge_n <= ~(ack & act);
         channel_busy <= act;
         cycle_start <= (owner_reg == 2'h0 && act[0]) || (owner_reg == 2'h1 && act[1]);
         cycle <= owner_reg == 2'h1 ? cyc1 : cyc0;
      end
   end
endmodule // dmace_engine

// File: sim/dmace_monitor.sv
// Purpose: port checker for the two-channel transfer engine
// Assumes: one clock, synchronous active-low reset
// Notes: bound to dmace_engine below
`timescale 1ns/1ns
module dmace_monitor (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire dmace_pkg::dmace_cfg_type cfg0,
   input wire logic refresh_req,
   input wire logic cycle_done,
   input wire logic end_of_process_line_out,
   input wire logic end_of_process_line_oe,
   input wire logic [1:0] channel_acknowledge_n,
   input wire logic refresh_grant,
   input wire logic hold_grant,
   input wire logic [1:0] channel_busy,
   input wire logic cycle_start,
   input wire dmace_pkg::dmace_cycle_type cycle
);
   import dmace_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_reset_outputs_quiet: assert property (disable iff (1'h0) !rst_n && ce |=>
      channel_acknowledge_n == 2'h3 && !end_of_process_line_oe && !refresh_grant
      && !hold_grant && channel_busy == 2'h0 && !cycle_start) else $error("reset outputs");
   a_line_drives_low: assert property (end_of_process_line_out == 1'h0)
      else $error("end of process line driven high");
   a_expiry_single_pulse: assert property (end_of_process_line_oe |=>
      !end_of_process_line_oe) else $error("end of process pulse too long");
   a_expiry_after_done: assert property (end_of_process_line_oe |-> $past(cycle_done)
      || $past(cycle_done, 2) || $past(cycle_done, 3)) else $error("expiry without transfer");
   a_refresh_owns_alone: assert property (refresh_grant |-> !hold_grant
      && channel_acknowledge_n == 2'h3 && !cycle_start) else $error("refresh shares bus");
   a_refresh_wins_free: assert property (refresh_req && !cycle_start && !hold_grant
      && channel_acknowledge_n == 2'h3 |-> ##[0:4] refresh_grant) else $error("refresh late");
   a_one_acknowledge: assert property ($onehot0(~channel_acknowledge_n)
      && !(hold_grant && channel_acknowledge_n != 2'h3)) else $error("two owners");
   a_cycle_holds: assert property (cycle_start && !cycle_done && !$past(cycle_done) |=>
      cycle_start && $stable(cycle)) else $error("cycle changed before done");
   a_flyby_memory: assert property (!channel_acknowledge_n[0] && cycle_start
      && cfg0.fly_by && cfg0.req_ext_io && cfg0.tgt_is_mem |->
      cycle.mem && cycle.write == cfg0.req_is_src) else $error("fly-by cycle kind");
   c_expiry: cover property (end_of_process_line_oe);
   c_refresh: cover property (refresh_grant);
   c_write_done: cover property (cycle_done && cycle.write);
endmodule // dmace_monitor
bind dmace_engine dmace_monitor mon (.clk, .rst_n, .ce, .cfg0, .refresh_req, .cycle_done,
   .end_of_process_line_out, .end_of_process_line_oe, .channel_acknowledge_n,
   .refresh_grant, .hold_grant, .channel_busy, .cycle_start, .cycle);

// File: sim/dmace_bus_model.sv
// Purpose: system bus and requester responder for the transfer engine
// Assumes: one outstanding cycle, a done pulse ends it
// Notes: slow adds three wait cycles; idle read data toggles
`timescale 1ns/1ns
module dmace_bus_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic slow,
   input wire logic cycle_start,
   input wire dmace_pkg::dmace_cycle_type cycle,
   output logic cycle_done,
   output logic [15:0] rdata
);
   import dmace_pkg::*;
   logic [1:0] wait_reg;
   logic gap_reg;
   wire logic serve = cycle_start && !cycle_done && !gap_reg;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wait_reg <= 2'h0;
         gap_reg <= 1'h0;
         cycle_done <= 1'h0;
         rdata <= 16'h0000;
      end else begin
         gap_reg <= cycle_done;
         cycle_done <= serve && (!slow || wait_reg == 2'h3);
         wait_reg <= serve ? wait_reg + 2'h1 : 2'h0;
         rdata <= serve ? {cycle.addr[7:0], ~cycle.addr[7:0]} : ~rdata;
      end
   end
endmodule // dmace_bus_model

// File: sim/tb_top.sv
// Purpose: self-checking bench for the two-channel transfer engine
// Assumes: inputs change 10 ns after the rising edge
// Notes: every scenario starts from reset
`timescale 1ns/1ns
module tb_top;
   import dmace_pkg::*;
   logic clk = 1'h0, rst_n = 1'h0, slow = 1'h0, eop_drv = 1'h1;
   logic refresh_req = 1'h0, hold_req = 1'h0, low_sel_we = 1'h0, rotate_en = 1'h0;
   logic [1:0] channel_request = 2'h0, sw_request = 2'h0, prog_we = 2'h0, low_sel = 2'h0;
   logic [3:0] periph_req1 = 4'h0;
   logic end_of_process_line_out, end_of_process_line_oe, refresh_grant, hold_grant;
   logic cycle_start, cycle_done;
   logic [1:0] channel_acknowledge_n, channel_busy;
   logic [15:0] rdata;
   wire logic end_of_process_line_in = eop_drv & !end_of_process_line_oe;
   dmace_cfg_type cfg0 = '0, cfg1 = '0;
   dmace_xfer_type prog = '0;
   dmace_cycle_type cycle;
   logic [25:0] aq[$];
   logic wq[$];
   int err_count = 0, compares = 0, eops = 0, seed = 32'hB7F6;
   dmace_engine uut (.clk, .rst_n, .ce(1'h1), .channel_request, .periph_req0(4'h0), .periph_req1,
      .sw_request, .cfg0, .cfg1, .prog, .prog_we, .refresh_req, .hold_req, .rotate_en,
      .low_sel_we, .low_sel, .cycle_done, .rdata, .end_of_process_line_in,
      .end_of_process_line_out, .end_of_process_line_oe, .channel_acknowledge_n,
      .refresh_grant, .hold_grant, .channel_busy, .cycle_start, .cycle);
   dmace_bus_model bus (.clk, .rst_n, .slow, .cycle_start, .cycle, .cycle_done, .rdata);
   initial forever #50 clk = ~clk;
   always @(posedge clk) if (cycle_done) begin
      aq.push_back(cycle.addr);
      wq.push_back(cycle.write);
   end
   always @(posedge clk) if (end_of_process_line_oe) eops++;
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #10;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic print_verdict();
      if (err_count == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic reboot();
      rst_n = 1'h0;
      tick(2);
      rst_n = 1'h1;
      aq.delete();
      wq.delete();
      eops = 0;
   endtask
   task automatic setcfg(input logic f, rw, tw, s, input dmace_bufmode_type m);
      cfg0 = '{f, 1'h1, !f, f, 1'h1, rw, tw, s, DMACE_ADDR_INC, DMACE_ADDR_INC, m, 3'h0};
      cfg1 = cfg0;
      cfg1.hw_src_sel = 3'h3;
   endtask
   task automatic load(input int ch, input logic [25:0] t, input logic [23:0] n);
      prog = '{26'h0000100, t, n};
      prog_we[ch] = 1'h1;
      tick(1);
      prog_we = 2'h0;
   endtask
   task automatic fly(input int ch, input dmace_bufmode_type m);
      logic [25:0] t;
      int n;
      t = 26'($random(seed)) & 26'h3FFFF00;
      n = 3 + ($random(seed) & 3);
      reboot();
      setcfg(1'h1, 1'h0, 1'h0, 1'h1, m);
      load(ch, t, 24'(n - 1));
      if (ch == 1) periph_req1[2] = 1'h1;
      else channel_request[0] = 1'h1;
      if (m == DMACE_BUF_CHAIN) begin
         for (int i = 0; i < 200 && aq.size() == 0; i++) tick(1);
         load(ch, t + 26'h80, 24'(n - 1));
      end
      tick(40 * n + 60);
      periph_req1 = 4'h0;
      channel_request = 2'h0;
      chk("expiry pulse", eops >= 1, 1);
      for (int i = 0; i < n; i++) chk("fly addr", aq[i], t + i);
      if (m == DMACE_BUF_SINGLE) chk("single count", aq.size(), n);
      if (m == DMACE_BUF_AUTO) chk("reload addr", aq[n], t);
      if (m == DMACE_BUF_CHAIN) chk("chain addr", aq[n], t + 26'h80);
      if (m == DMACE_BUF_CHAIN) chk("chain end", aq.size(), 2 * n);
   endtask
   task automatic twin(input logic w);
      int k;
      int b;
      int rd;
      int wr;
      reboot();
      setcfg(1'h0, w, !w, 1'h1, DMACE_BUF_SINGLE);
      load(1, 26'h0000400, 24'h000005);
      sw_request[1] = 1'h1;
      tick(300);
      sw_request = 2'h0;
      k = 0;
      for (int rem = 6; rem > 0; rem -= b) begin
         b = rem > 4 ? 4 : rem;
         rd = w ? (b + 1) / 2 : b;
         wr = w ? b : (b + 1) / 2;
         for (int i = 0; i < rd + wr; i++) begin
            chk("bus direction", wq[k], i >= rd);
            k++;
         end
      end
      chk("bus cycles", wq.size(), k);
   endtask
   task automatic stop(input logic s);
      reboot();
      slow = 1'h1;
      setcfg(1'h1, 1'h0, 1'h0, s, DMACE_BUF_SINGLE);
      load(0, 26'h0000200, 24'h000028);
      channel_request[0] = 1'h1;
      for (int i = 0; i < 400 && aq.size() < 2; i++) tick(1);
      eop_drv = 1'h0;
      tick(12);
      eop_drv = 1'h1;
      tick(80);
      chk("early stop", aq.size() < 8, 1);
      chk("stopped idle", channel_busy[0], 0);
      channel_request = 2'h0;
      slow = 1'h0;
   endtask
   task automatic arb(input int s);
      int own;
      int last;
      int e;
      int rc;
      int hc;
      int q[$];
      reboot();
      e = s < 3 ? s : 2;
      rotate_en = s == 3;
      setcfg(1'h1, 1'h0, 1'h0, 1'h1, DMACE_BUF_SINGLE);
      if (s < 3) begin
         low_sel = 2'(s);
         low_sel_we = 1'h1;
         tick(1);
         low_sel_we = 1'h0;
      end
      load(0, 26'h0000300, 24'h000000);
      load(1, 26'h0000340, 24'h000000);
      refresh_req = 1'h1;
      hold_req = 1'h1;
      channel_request[0] = 1'h1;
      periph_req1[2] = 1'h1;
      last = 4;
      rc = 0;
      hc = 0;
      for (int i = 0; i < 300; i++) begin
         own = !channel_acknowledge_n[0] ? 0 : !channel_acknowledge_n[1] ? 1 :
            hold_grant ? 2 : refresh_grant ? 3 : 4;
         if (own != 4 && own != last) q.push_back(own);
         if (own != 4) last = own;
         rc += refresh_grant;
         hc += hold_grant;
         if (rc == 6) refresh_req = 1'h0;
         if (hc == 3) hold_req = 1'h0;
         tick(1);
      end
      channel_request = 2'h0;
      periph_req1 = 4'h0;
      chk("owner count", q.size(), 4);
      chk("first owner", q[0], 3);
      chk("second owner", q[1], (e + 1) % 3);
      chk("third owner", q[2], (e + 2) % 3);
      chk("last owner", q[3], e);
      rotate_en = 1'h0;
   endtask
   initial begin
      #2000000;
      err_count++;
      print_verdict();
   end
   initial begin
      #10;
      fly(0, DMACE_BUF_SINGLE);
      fly(1, DMACE_BUF_AUTO);
      fly(1, DMACE_BUF_CHAIN);
      for (int w = 0; w < 2; w++) twin(w[0]);
      for (int s = 0; s < 2; s++) stop(s[0]);
      for (int s = 0; s < 4; s++) arb(s);
      print_verdict();
   end
endmodule // tb_top
